// ==== rtl/nsp_framer.sv ====
// Purpose: Serialises navigation state payloads into a byte stream.
// Assumes: Requests come from logic on i_clock; the sink uses valid and ready.
// Notes:   Header and checksum are added downstream from o_id and o_len.
`timescale 1ns/100ps
`default_nettype none
`include "nsp_regs.svh"

module nsp_framer (
    input  wire logic               i_clock,
    input  wire logic               i_sys_rst,
    input  wire logic               i_req_valid,
    input  wire nsp_pkg::nsp_req_t  i_req,
    output var  logic               o_req_ready,
    output var  logic               o_beat_valid,
    input  wire logic               i_beat_ready,
    output var  nsp_pkg::nsp_beat_t o_beat,
    output var  logic [7:0]         o_id,
    output var  logic [5:0]         o_len,
    output var  logic               o_bad_id
);

    localparam int IMG_W = `NSP_WORDS * 32;

    // ==========================================================
    // Length lookup
    // An unknown identifier maps to zero length, which refuses it.
    function automatic logic [5:0] nsp_len(input logic [7:0] id);
        case (id)
            `NSP_ID_UTM:  nsp_len = `NSP_LEN_UTM;
            `NSP_ID_NEDV: nsp_len = `NSP_LEN_VEC3;
            `NSP_ID_BODV: nsp_len = `NSP_LEN_VEC3;
            `NSP_ID_ACC:  nsp_len = `NSP_LEN_VEC3;
            `NSP_ID_BACC: nsp_len = `NSP_LEN_VEC4;
            `NSP_ID_EUL:  nsp_len = `NSP_LEN_VEC3;
            `NSP_ID_QUAT: nsp_len = `NSP_LEN_VEC4;
            `NSP_ID_DCM:  nsp_len = `NSP_LEN_DCM;
            `NSP_ID_ANGV: nsp_len = `NSP_LEN_VEC3;
            `NSP_ID_ANGA: nsp_len = `NSP_LEN_VEC3;
            default:      nsp_len = `NSP_LEN_NONE;
        endcase
    endfunction

    // ==========================================================
    // State
    nsp_pkg::nsp_state_t state_q;
    nsp_pkg::nsp_state_t state_d;
    logic [IMG_W-1:0]    image_q;
    logic [IMG_W-1:0]    image_d;
    logic [5:0]          cnt_q;
    logic [5:0]          cnt_d;
    logic                ready_q;
    logic                ready_d;
    logic                valid_q;
    logic                valid_d;
    nsp_pkg::nsp_beat_t  beat_q;
    nsp_pkg::nsp_beat_t  beat_d;
    logic [7:0]          id_q;
    logic [7:0]          id_d;
    logic [5:0]          len_q;
    logic [5:0]          len_d;
    logic                bad_q;
    logic                bad_d;
    logic [5:0]          req_len;
    logic                take;

    assign req_len = nsp_len(i_req.id);
    assign take    = valid_q && i_beat_ready;

    // ==========================================================
    // Next state
    // Word n of the request lands at byte 4n, low byte first, so doubles are
    // two adjacent words and the image has no padding between fields.
    always_comb begin
        state_d = state_q;
        image_d = image_q;
        cnt_d   = cnt_q;
        ready_d = ready_q;
        valid_d = valid_q;
        beat_d  = beat_q;
        id_d    = id_q;
        len_d   = len_q;
        bad_d   = 1'b0;
        case (state_q)
            nsp_pkg::NSP_IDLE: begin
                if (i_req_valid && ready_q) begin
                    if (req_len != `NSP_LEN_NONE) begin
                        image_d     = i_req.words >> 8;
                        beat_d.data = i_req.words[7:0];
                        beat_d.sop  = 1'b1;
                        beat_d.eop  = 1'b0;
                        cnt_d       = req_len - 6'h01;
                        id_d        = i_req.id;
                        len_d       = req_len;
                        valid_d     = 1'b1;
                        ready_d     = 1'b0;
                        state_d     = nsp_pkg::NSP_SEND;
                    end else begin
                        bad_d = 1'b1;
                    end
                end
            end
            nsp_pkg::NSP_SEND: begin
                if (take) begin
                    if (cnt_q == 6'h00) begin
                        valid_d    = 1'b0;
                        ready_d    = 1'b1;
                        beat_d.sop = 1'b0;
                        beat_d.eop = 1'b0;
                        state_d    = nsp_pkg::NSP_IDLE;
                    end else begin
                        beat_d.data = image_q[7:0];
                        beat_d.sop  = 1'b0;
                        beat_d.eop  = (cnt_q == 6'h01);
                        image_d     = image_q >> 8;
                        cnt_d       = cnt_q - 6'h01;
                    end
                end
            end
            default: begin
                state_d = nsp_pkg::NSP_IDLE;
                valid_d = 1'b0;
                ready_d = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= nsp_pkg::NSP_IDLE;
            image_q <= '0;
            cnt_q   <= 6'h00;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
            beat_q  <= '0;
            id_q    <= 8'h00;
            len_q   <= 6'h00;
            bad_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            image_q <= image_d;
            cnt_q   <= cnt_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
            beat_q  <= beat_d;
            id_q    <= id_d;
            len_q   <= len_d;
            bad_q   <= bad_d;
        end
    end

    assign o_req_ready  = ready_q;
    assign o_beat_valid = valid_q;
    assign o_beat       = beat_q;
    assign o_id         = id_q;
    assign o_len        = len_q;
    assign o_bad_id     = bad_q;

    // ==========================================================
    // Checks
    // A byte counter per packet lets the length checks see the whole frame.
    logic [5:0]       sent_q;
    logic [5:0]       sent_d;
    logic [7:0]       low_q;
    logic [IMG_W-1:0] copy_q;
    logic [IMG_W-1:0] copy_d;

    always_comb begin
        sent_d = sent_q;
        if (state_q == nsp_pkg::NSP_IDLE) begin
            sent_d = 6'h00;
        end else if (take) begin
            sent_d = sent_q + 6'h01;
        end
    end

    // The image is copied at acceptance so every byte, not only the first, is held
    // against its place; nothing but the checks reads it, so synthesis drops it.
    always_comb begin
        copy_d = copy_q;
        if (i_req_valid && ready_q && (req_len != `NSP_LEN_NONE)) begin
            copy_d = i_req.words;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sent_q <= 6'h00;
            low_q  <= 8'h00;
            copy_q <= '0;
        end else begin
            sent_q <= sent_d;
            low_q  <= i_req.words[7:0];
            copy_q <= copy_d;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence s_accept;
        i_req_valid && o_req_ready && (nsp_len(i_req.id) != `NSP_LEN_NONE);
    endsequence

    sequence s_first;
        o_beat_valid && o_beat.sop && !o_req_ready;
    endsequence

    sequence s_take_byte;
        o_beat_valid && i_beat_ready;
    endsequence

    a_utm_len: assert property (
        s_first and (o_id == `NSP_ID_UTM) |-> o_len == `NSP_LEN_UTM)
        else $error("UTM payload length wrong.");
    a_nedv_len: assert property (
        s_first and (o_id == `NSP_ID_NEDV) |-> o_len == `NSP_LEN_VEC3)
        else $error("NED velocity payload length wrong.");
    a_bodv_len: assert property (
        s_first and (o_id == `NSP_ID_BODV) |-> o_len == `NSP_LEN_VEC3)
        else $error("Body velocity payload length wrong.");
    a_acc_len: assert property (
        s_first and (o_id == `NSP_ID_ACC) |-> o_len == `NSP_LEN_VEC3)
        else $error("Acceleration payload length wrong.");
    a_bacc_len: assert property (
        s_first and (o_id == `NSP_ID_BACC) |-> o_len == `NSP_LEN_VEC4)
        else $error("Body acceleration payload length wrong.");
    a_euler_len: assert property (
        s_first and (o_id == `NSP_ID_EUL) |-> o_len == `NSP_LEN_VEC3)
        else $error("Euler payload length wrong.");
    a_quat_len: assert property (
        s_first and (o_id == `NSP_ID_QUAT) |-> o_len == `NSP_LEN_VEC4)
        else $error("Quaternion payload length wrong.");
    a_dcm_len: assert property (
        s_first and (o_id == `NSP_ID_DCM) |-> o_len == `NSP_LEN_DCM)
        else $error("Matrix payload length wrong.");
    a_angv_len: assert property (
        s_first and (o_id == `NSP_ID_ANGV) |-> o_len == `NSP_LEN_VEC3)
        else $error("Angular velocity payload length wrong.");
    a_anga_len: assert property (
        s_first and (o_id == `NSP_ID_ANGA) |-> o_len == `NSP_LEN_VEC3)
        else $error("Angular acceleration payload length wrong.");

    a_first_byte: assert property (
        s_accept |=> s_first ##0 (o_beat.data == low_q))
        else $error("First payload byte is not the low byte of word 0.");

    a_frame_count: assert property (
        o_beat_valid && i_beat_ready && o_beat.eop |-> sent_q + 6'h01 == o_len)
        else $error("Frame byte count differs from payload length.");

    a_stall_hold: assert property (
        o_beat_valid && !i_beat_ready |=> o_beat_valid && $stable(o_beat))
        else $error("Beat changed while the sink stalled.");

    a_frame_done: assert property (
        o_beat_valid && i_beat_ready && o_beat.eop |=> o_req_ready && !o_beat_valid)
        else $error("Framer not idle after the last byte.");

    a_bad_refused: assert property (
        i_req_valid && o_req_ready && (nsp_len(i_req.id) == `NSP_LEN_NONE)
        |=> o_bad_id && o_req_ready && !o_beat_valid)
        else $error("Unknown identifier not refused.");

    a_byte_order: assert property (
        o_beat_valid |-> o_beat.data == copy_q[8*sent_q+:8])
        else $error("Payload byte is not taken from its place in the image.");

    a_zone_last: assert property (
        o_beat_valid && (o_id == `NSP_ID_UTM) && (sent_q == 6'(`NSP_OFS_ZONE)) |-> o_beat.eop)
        else $error("Zone byte is not the last byte of the UTM payload.");

    a_busy_excl: assert property (
        o_beat_valid != o_req_ready)
        else $error("Ready and byte valid are not exclusive.");

    a_sop_first: assert property (
        o_beat_valid && o_beat.sop |-> sent_q == 6'h00)
        else $error("Start flag on a byte other than the first.");

    a_no_early_end: assert property (
        o_beat_valid && !o_beat.eop |-> sent_q + 6'h01 < o_len)
        else $error("Frame runs past its payload length.");

    a_hdr_stable: assert property (
        o_beat_valid |=> $stable(o_id) && $stable(o_len))
        else $error("Identifier or length changed inside a frame.");

    a_next_byte: assert property (
        s_take_byte ##0 !o_beat.eop
        |=> o_beat_valid && !o_beat.sop && (sent_q == $past(sent_q) + 6'h01))
        else $error("Next payload byte did not follow a taken byte.");

    a_accept_id: assert property (
        s_accept |=> (o_id == $past(i_req.id)) && (o_len == nsp_len(o_id)))
        else $error("Accepted identifier or its length not presented.");

    a_bad_quiet: assert property (
        o_bad_id |-> o_req_ready && !o_beat_valid)
        else $error("Refusal flagged while a frame is running.");

endmodule

`default_nettype wire

// ==== rtl/nsp_regs.svh ====
// Purpose: Constants of the navigation state packet framer.
// Assumes: Included by the package and the framer by bare name.
// Notes:   Identifiers, payload lengths and field offsets in bytes.
//
// Functional notes
// - UTM position has identifier 34, 25 bytes: doubles at 0, 8, 16 and signed zone at 24.
// - NED velocity has identifier 35, 12 bytes: north, east, down singles at 0, 4, 8.
// - The body velocity packet has identifier 36 and 12 bytes: X, Y, Z as singles at 0, 4, 8.
// - The acceleration packet has identifier 37 and 12 bytes: X, Y, Z as singles at 0, 4, 8.
// - Body acceleration has identifier 38, 16 bytes: X, Y, Z at 0, 4, 8 and G force at 12.
// - The Euler packet has identifier 39 and 12 bytes: roll, pitch, heading at 0, 4, 8.
// - Quaternion has identifier 40, 16 bytes: components zero to three at 0, 4, 8, 12.
// - Cosine matrix has identifier 41, 36 bytes: row r, column c at 4 times (3r plus c).
// - The angular velocity packet has identifier 42 and 12 bytes: X, Y, Z at 0, 4, 8.
// - The angular acceleration packet has identifier 43 and 12 bytes: X, Y, Z at 0, 4, 8.
`ifndef NSP_REGS_SVH
`define NSP_REGS_SVH

// ==========================================================
// Packet identifiers
`define NSP_ID_UTM   8'h22
`define NSP_ID_NEDV  8'h23
`define NSP_ID_BODV  8'h24
`define NSP_ID_ACC   8'h25
`define NSP_ID_BACC  8'h26
`define NSP_ID_EUL   8'h27
`define NSP_ID_QUAT  8'h28
`define NSP_ID_DCM   8'h29
`define NSP_ID_ANGV  8'h2A
`define NSP_ID_ANGA  8'h2B

// ==========================================================
// Payload lengths in bytes
`define NSP_LEN_UTM  6'h19
`define NSP_LEN_VEC3 6'h0C
`define NSP_LEN_VEC4 6'h10
`define NSP_LEN_DCM  6'h24
`define NSP_LEN_NONE 6'h00

// ==========================================================
// Field offsets and image size
`define NSP_OFS_ZONE 5'h18
`define NSP_WORDS    9

`endif

// ==== rtl/nsp_pkg.sv ====
// Purpose: Types of the navigation state packet framer.
// Assumes: nsp_regs.svh holds the numbers.
// Notes:   The payload image is little-endian, word 0 in the low bits.
`include "nsp_regs.svh"

package nsp_pkg;

    // ==========================================================
    // State and carriers
    typedef enum logic [1:0] {
        NSP_IDLE = 2'b00,
        NSP_SEND = 2'b01
    } nsp_state_t;

    typedef struct packed {
        logic [7:0]                id;
        logic [`NSP_WORDS*32-1:0]  words;
    } nsp_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic       sop;
        logic       eop;
    } nsp_beat_t;

endpackage

// ==== test/nsp_host_model.sv ====
// Purpose: Host side model that takes payload bytes from the framer.
// Assumes: One clock; stalls come from a seeded random stream when enabled.
// Notes:   Flags a frame whose byte count differs from the framer's length.
`timescale 1ns/100ps
`default_nettype none

module nsp_host_model (
    input  wire logic               i_clock,
    input  wire logic               i_sys_rst,
    input  wire logic               i_stall,
    input  wire logic               i_beat_valid,
    input  wire nsp_pkg::nsp_beat_t i_beat,
    input  wire logic [5:0]         i_len,
    output var  logic               o_ready,
    output var  logic               o_len_bad
);
    integer seed;
    integer cnt;

    initial seed = 32'hB4DF;

    // ==========================================================
    // Byte sink
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ready   <= 1'b0;
            o_len_bad <= 1'b0;
            cnt = 0;
        end else begin
            o_len_bad <= 1'b0;
            if (i_beat_valid && o_ready) begin
                cnt = i_beat.sop ? 1 : cnt + 1;
                // A short or long frame is flagged by the receiver on its end byte.
                if (i_beat.eop && cnt != i_len) begin
                    o_len_bad <= 1'b1;
                end
            end
            o_ready <= i_stall ? 1'($random(seed)) : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench of the navigation state packet framer.
// Assumes: Inputs change at rising edges; outputs are sampled at falling edges.
// Notes:   Every known identifier is sent with and without host stalls; unknown ones are sent once each.
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic               i_clock;
    logic               i_sys_rst;
    logic               i_req_valid;
    logic               stall;
    logic               o_req_ready;
    logic               o_beat_valid;
    logic               o_bad_id;
    logic               host_ready;
    logic               len_bad;
    logic [7:0]         o_id;
    logic [5:0]         o_len;
    nsp_pkg::nsp_req_t  i_req;
    nsp_pkg::nsp_beat_t o_beat;
    logic [7:0]         exp_q[$];
    integer             error_cnt;
    integer             n_tests;
    integer             seed;
    integer             id;

    nsp_framer u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_beat_valid(o_beat_valid),
        .i_beat_ready(host_ready), .o_beat(o_beat), .o_id(o_id), .o_len(o_len),
        .o_bad_id(o_bad_id));

    nsp_host_model u_host (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_stall(stall),
        .i_beat_valid(o_beat_valid), .i_beat(o_beat), .i_len(o_len), .o_ready(host_ready),
        .o_len_bad(len_bad));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    // ==========================================================
    // Checking helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic int len_of(input int pid);
        case (pid)
            34: return 25;
            38, 40: return 16;
            41: return 36;
            35, 36, 37, 39, 42, 43: return 12;
            default: return 0;
        endcase
    endfunction

    task automatic summarize;
        $display("errors=%0d comparisons=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // One request and its whole frame; with stalls, a busy request is held to prove it is ignored.
    task automatic send(input int pid, input logic stl);
        int n;
        int t;
        int len;
        logic [287:0] w;
        for (n = 0; n < 9; n++) begin
            w[32*n+:32] = $random(seed);
        end
        len = len_of(pid);
        exp_q.delete();
        for (n = 0; n < len; n++) begin
            exp_q.push_back(w[8*n+:8]);
        end
        t = 0;
        while (o_req_ready !== 1'b1) begin
            @(negedge i_clock);
            t++;
            if (t > 100) begin
                error_cnt++;
                summarize();
            end
        end
        @(posedge i_clock);
        i_req_valid <= 1'b1;
        i_req       <= '{id: 8'(pid), words: w};
        stall       <= stl;
        @(posedge i_clock);
        i_req_valid <= stl && len != 0;
        i_req.id    <= 8'h23;
        @(negedge i_clock);
        if (len == 0) begin
            check(o_bad_id, 1'b1);
            check({o_req_ready, o_beat_valid}, 2'b10);
            @(negedge i_clock);
            check(o_bad_id, 1'b0);
            return;
        end
        n = 0;
        t = 0;
        while (n < len && t < 500) begin
            check({o_req_ready, len_bad}, 2'b00);
            if (o_beat_valid && host_ready) begin
                check(o_beat.data, exp_q.pop_front());
                check({o_beat.sop, o_beat.eop}, {n == 0, n == len - 1});
                check({o_id, o_len}, {8'(pid), 6'(len)});
                n++;
            end
            t++;
            if (n < len) begin
                @(negedge i_clock);
            end
        end
        check(n, len);
        check(exp_q.size(), 0);
        @(posedge i_clock);
        i_req_valid <= 1'b0;
        @(negedge i_clock);
        check({o_req_ready, o_beat_valid, len_bad}, 3'b100);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        error_cnt   = 0;
        n_tests     = 0;
        seed        = 32'hB4DF;
        i_sys_rst   = 1'b1;
        i_req_valid = 1'b0;
        i_req       = '0;
        stall       = 1'b0;
        repeat (20) @(posedge i_clock);
        @(negedge i_clock);
        check({o_req_ready, o_beat_valid, o_bad_id, o_id, o_len}, {3'b100, 14'h0000});
        @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (id = 34; id <= 43; id++) begin
            send(id, 1'b0);
            send(id, 1'b1);
        end
        send(33, 1'b0);
        send(44, 1'b1);
        send(255, 1'b0);
        send(34, 1'b1);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        error_cnt = error_cnt + 1;
        summarize();
    end
endmodule
`default_nettype wire
